// ===== rtl/mise_pkg.sv
// package of constants and carrier types for the instruction subset executor
// assumes a single instruction clock and an apb master for the register window
//
// Functional notes
// RL1: special-page read copies selected special register into accumulator, one cycle, no flags.
// RL2: special-page write loads accumulator into selected special register, one cycle.
// RL3: file minus accumulator, two's complement, one cycle, updates zero, digit carry, carry.
// RL4: destination bit zero writes accumulator, one writes addressed file register.
// RL5: immediate minus accumulator into accumulator, one cycle, updates zero, digit carry, carry.
// RL6: nibble swap exchanges register halves into destination, one cycle, flags kept.
// RL7: table read addresses rom with pointer bits 2:0 above accumulator, low byte, two cycles.
// RL8: table read loads upper six rom bits into table high data bits 5:0.
// RL9: timer zero mode read copies mode register into accumulator, one cycle, no flags.
// RL10: timer zero mode write loads accumulator into mode register, one cycle, no flags.
// RL11: file xor accumulator in one cycle, result routed by destination bit.
// RL12: immediate xor accumulator into accumulator, one cycle, only zero flag updated.
// RL13: subtraction carry cleared on borrow, set otherwise; zero set on zero result.
// RL14: file xor sets zero on zero result, keeps carry and digit carry.
package mise_pkg;

  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RD_SPECIAL = 4'h1;
  localparam logic [3:0] OP_WR_SPECIAL = 4'h2;
  localparam logic [3:0] OP_SUB_FILE = 4'h3;
  localparam logic [3:0] OP_SUB_IMM = 4'h4;
  localparam logic [3:0] OP_SWAP = 4'h5;
  localparam logic [3:0] OP_TABLE = 4'h6;
  localparam logic [3:0] OP_RD_T0MODE = 4'h7;
  localparam logic [3:0] OP_WR_T0MODE = 4'h8;
  localparam logic [3:0] OP_XOR_FILE = 4'h9;
  localparam logic [3:0] OP_XOR_IMM = 4'ha;

  // ----------------------------------------
  // apb register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_T0MODE = 8'h0c;
  localparam logic [7:0] OFS_TBL_PTR = 8'h10;
  localparam logic [7:0] OFS_TBL_DATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_FILE_BASE = 8'h40;
  localparam logic [7:0] OFS_SPECIAL_BASE = 8'h80;
  localparam logic [7:0] OFS_ROM_ADDR = 8'hc0;
  localparam logic [7:0] OFS_ROM_DATA = 8'hc4;

  // ----------------------------------------
  // command word fields
  // ----------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_DC_BIT = 1;
  localparam int FLAG_Z_BIT = 2;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int FILE_DEPTH = 64;
  localparam int SPECIAL_DEPTH = 16;
  localparam int ROM_DEPTH = 2048;
  localparam int ROM_WIDTH = 14;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] TABLE_CYCLES = 3'h2;

  typedef struct packed {
    logic [7:0] imm;
    logic [1:0] pad;
    logic [5:0] addr;
    logic [2:0] rsv;
    logic dest;
    logic [3:0] op;
  } mise_cmd_type;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } mise_flags_type;

endpackage

// ===== rtl/mise_alu.sv
// combinational alu for subtract, swap and xor
// assumes operands held stable by the executor during the cycle
module mise_alu (
  input wire logic [3:0] op,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] opnd,
  input wire mise_pkg::mise_flags_type flags_in,
  output logic [7:0] result,
  output mise_pkg::mise_flags_type flags_out
);
  wire logic [8:0] diff = {1'b0, opnd} - {1'b0, acc_in};
  wire logic [4:0] ldiff = {1'b0, opnd[3:0]} - {1'b0, acc_in[3:0]};
  wire logic is_sub = (op == mise_pkg::OP_SUB_FILE) || (op == mise_pkg::OP_SUB_IMM);
  wire logic is_xor = (op == mise_pkg::OP_XOR_FILE) || (op == mise_pkg::OP_XOR_IMM);
  wire logic [7:0] xor_val = acc_in ^ opnd;
  wire logic [7:0] swap_val = {opnd[3:0], opnd[7:4]}; // RL6

  assign result = is_sub ? diff[7:0] : (is_xor ? xor_val : swap_val); // RL3 RL5 RL11

  // borrow clears carry; xor touches only zero
  assign flags_out.c = is_sub ? ~diff[8] : flags_in.c; // RL13
  assign flags_out.dc = is_sub ? ~ldiff[4] : flags_in.dc; // RL3 RL5 RL14
  assign flags_out.z = is_sub ? (diff[7:0] == 8'h00) : (is_xor ? (xor_val == 8'h00) : flags_in.z); // RL12 RL13 RL14
endmodule

// ===== rtl/mise_top.sv
// instruction subset executor with apb register window
// assumes the apb master follows the protocol and loads rom through the window
//
// The implementer's own choices: the register addresses and register access over APB.
module mise_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);

  typedef enum logic [2:0] {
    MISE_IDLE = 3'b001,
    MISE_TBL1 = 3'b010,
    MISE_TBL2 = 3'b100
  } mise_state_type;

  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  mise_state_type state;
  logic [7:0] accumulator;
  mise_pkg::mise_flags_type flags;
  logic [7:0] timer_zero_mode_reg;
  logic [7:0] table_high_pointer;
  logic [7:0] table_high_data;
  logic [7:0] file_mem [mise_pkg::FILE_DEPTH];
  logic [7:0] special_mem [mise_pkg::SPECIAL_DEPTH];
  logic [13:0] rom_mem [mise_pkg::ROM_DEPTH];
  logic [10:0] rom_addr;
  logic [10:0] table_addr;
  logic [13:0] rom_word;
  mise_pkg::mise_cmd_type cmd;
  logic access_d;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic setup = psel && !penable;
  wire logic acc_ph = psel && penable;
  wire logic wr_cyc = acc_ph && pwrite && pready;
  wire logic hit_cmd = paddr == mise_pkg::OFS_CMD;
  wire logic hit_acc = paddr == mise_pkg::OFS_ACC;
  wire logic hit_flags = paddr == mise_pkg::OFS_FLAGS;
  wire logic hit_t0 = paddr == mise_pkg::OFS_T0MODE;
  wire logic hit_ptr = paddr == mise_pkg::OFS_TBL_PTR;
  wire logic hit_tdata = paddr == mise_pkg::OFS_TBL_DATA;
  wire logic hit_status = paddr == mise_pkg::OFS_STATUS;
  wire logic hit_file = paddr[7:6] == 2'b01 && paddr[1:0] == 2'b00;
  wire logic hit_spec = paddr[7:6] == 2'b10 && paddr[1:0] == 2'b00;
  wire logic hit_raddr = paddr == mise_pkg::OFS_ROM_ADDR;
  wire logic hit_rdata = paddr == mise_pkg::OFS_ROM_DATA;
  wire logic hit_any = hit_cmd || hit_acc || hit_flags || hit_t0 || hit_ptr || hit_tdata || hit_status
    || hit_file || hit_spec || hit_raddr || hit_rdata;
  wire logic [5:0] file_idx = paddr[7:2] - 6'h10;
  wire logic [3:0] spec_idx = paddr[5:2];
  wire logic idle = state == MISE_IDLE;
  // all writes are held off while a table read runs; reads of any register are not
  wire logic stall = !idle && pwrite;

  // ----------------------------------------
  // instruction launch
  // ----------------------------------------
  wire logic exec = wr_cyc && hit_cmd && idle;
  wire mise_pkg::mise_cmd_type new_cmd = mise_pkg::mise_cmd_type'(pwdata[23:0]);
  wire logic [3:0] op = new_cmd.op;
  wire logic [7:0] file_val = file_mem[new_cmd.addr];
  wire logic [7:0] alu_opnd = (op == mise_pkg::OP_SUB_IMM || op == mise_pkg::OP_XOR_IMM) ? new_cmd.imm : file_val;
  logic [7:0] alu_res;
  mise_pkg::mise_flags_type alu_flags;

  mise_alu u_alu (
    .op(op),
    .acc_in(accumulator),
    .opnd(alu_opnd),
    .flags_in(flags),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  wire logic is_alu = op == mise_pkg::OP_SUB_FILE || op == mise_pkg::OP_SUB_IMM || op == mise_pkg::OP_SWAP
    || op == mise_pkg::OP_XOR_FILE || op == mise_pkg::OP_XOR_IMM;
  wire logic has_dest = op == mise_pkg::OP_SUB_FILE || op == mise_pkg::OP_SWAP || op == mise_pkg::OP_XOR_FILE;
  wire logic to_file = exec && is_alu && has_dest && new_cmd.dest; // RL4
  wire logic to_acc_alu = exec && is_alu && !(has_dest && new_cmd.dest); // RL4 RL5 RL12
  wire logic [3:0] spec_sel = new_cmd.imm[3:0];

  // ----------------------------------------
  // next accumulator
  // ----------------------------------------
  wire logic [7:0] next_acc =
    to_acc_alu ? alu_res :
    (exec && op == mise_pkg::OP_RD_SPECIAL) ? special_mem[spec_sel] : // RL1
    (exec && op == mise_pkg::OP_RD_T0MODE) ? timer_zero_mode_reg : // RL9
    (state == MISE_TBL2) ? rom_word[7:0] : // RL7
    (wr_cyc && hit_acc && idle) ? pwdata[7:0] : accumulator;

  wire mise_pkg::mise_flags_type next_flags =
    (exec && is_alu) ? alu_flags : // RL3 RL13 RL14
    (wr_cyc && hit_flags && idle) ? mise_pkg::mise_flags_type'(pwdata[2:0]) : flags;

  // ----------------------------------------
  // table read sequencing
  // ----------------------------------------
  wire logic tbl_start = exec && op == mise_pkg::OP_TABLE;
  mise_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      MISE_IDLE: begin
        if (tbl_start) begin
          next_state = MISE_TBL1;
        end
      end
      MISE_TBL1: begin
        next_state = MISE_TBL2;
      end
      MISE_TBL2: begin
        next_state = MISE_IDLE;
      end
      default: begin
        next_state = MISE_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MISE_IDLE;
      accumulator <= mise_pkg::RST_BYTE;
      flags <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      accumulator <= next_acc;
      flags <= next_flags;
      busy <= next_state != MISE_IDLE;
    end
  end

  // pointer bits 2:0 above the accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_addr <= '0;
      rom_word <= '0;
    end else begin
      if (tbl_start) begin
        table_addr <= {table_high_pointer[2:0], accumulator}; // RL7
      end
      if (state == MISE_TBL1) begin
        rom_word <= rom_mem[table_addr]; // RL7
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_high_data <= mise_pkg::RST_BYTE;
      table_high_pointer <= mise_pkg::RST_BYTE;
      timer_zero_mode_reg <= mise_pkg::RST_BYTE;
      rom_addr <= '0;
    end else begin
      if (state == MISE_TBL2) begin
        table_high_data <= {2'b00, rom_word[13:8]}; // RL8
      end else if (wr_cyc && hit_tdata && idle) begin
        table_high_data <= pwdata[7:0];
      end
      if (wr_cyc && hit_ptr && idle) begin
        table_high_pointer <= pwdata[7:0];
      end
      if (exec && op == mise_pkg::OP_WR_T0MODE) begin
        timer_zero_mode_reg <= accumulator; // RL10
      end else if (wr_cyc && hit_t0 && idle) begin
        timer_zero_mode_reg <= pwdata[7:0];
      end
      if (wr_cyc && hit_raddr && idle) begin
        rom_addr <= pwdata[10:0];
      end
    end
  end

  // ----------------------------------------
  // storage arrays
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (to_file) begin
      file_mem[new_cmd.addr] <= alu_res; // RL4 RL11
    end else if (wr_cyc && hit_file && idle) begin
      file_mem[file_idx] <= pwdata[7:0];
    end
    if (exec && op == mise_pkg::OP_WR_SPECIAL) begin
      special_mem[spec_sel] <= accumulator; // RL2
    end else if (wr_cyc && hit_spec && idle) begin
      special_mem[spec_idx] <= pwdata[7:0];
    end
    if (wr_cyc && hit_rdata && idle) begin
      rom_mem[rom_addr] <= pwdata[13:0];
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  wire logic [31:0] rd_mux =
    hit_acc ? {24'h0, accumulator} :
    hit_flags ? {29'h0, flags} :
    hit_t0 ? {24'h0, timer_zero_mode_reg} :
    hit_ptr ? {24'h0, table_high_pointer} :
    hit_tdata ? {24'h0, table_high_data} :
    hit_status ? {31'h0, busy} :
    hit_file ? {24'h0, file_mem[file_idx]} :
    hit_spec ? {24'h0, special_mem[spec_idx]} :
    hit_raddr ? {21'h0, rom_addr} :
    hit_rdata ? {18'h0, rom_mem[rom_addr]} : 32'h0;

  // one wait state; writes stretch until the table read ends
  wire logic next_ready = acc_ph && !pready && access_d && !stall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_d <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      access_d <= setup || (acc_ph && !pready);
      pready <= next_ready;
      pslverr <= next_ready && !hit_any;
      prdata <= (next_ready && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_tbl_run;
    state == MISE_TBL1 ##1 state == MISE_TBL2;
  endsequence

  a_table_two_cycles: assert property (@(posedge pclk) disable iff (!presetn) tbl_start |=> s_tbl_run) // RL7
    else $error("table read did not take two cycles");
  a_table_high_data: assert property (@(posedge pclk) disable iff (!presetn)
    state == MISE_TBL2 |=> table_high_data == {2'b00, $past(rom_word[13:8])}) // RL8
    else $error("table high data not loaded");
  a_table_acc_load: assert property (@(posedge pclk) disable iff (!presetn)
    state == MISE_TBL2 |=> accumulator == $past(rom_word[7:0])) // RL7
    else $error("table low byte not in accumulator");
  a_t0_write_load: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op == mise_pkg::OP_WR_T0MODE |=> timer_zero_mode_reg == $past(accumulator) && flags == $past(flags)) // RL10
    else $error("timer mode write wrong");
  a_t0_read_copy: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op == mise_pkg::OP_RD_T0MODE |=> accumulator == $past(timer_zero_mode_reg) && $stable(flags)) // RL9
    else $error("timer mode read wrong");
  a_special_read: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op == mise_pkg::OP_RD_SPECIAL |=> $stable(flags)) // RL1
    else $error("special read changed flags");
  a_sub_carry: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op == mise_pkg::OP_SUB_IMM |=> flags.c == ($past(new_cmd.imm) >= $past(accumulator))) // RL13
    else $error("subtract carry wrong");
  a_sub_imm_acc: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op == mise_pkg::OP_SUB_IMM |=> accumulator == 8'($past(new_cmd.imm) - $past(accumulator))) // RL5
    else $error("subtract result wrong");
  a_xor_imm_flags: assert property (@(posedge pclk) disable iff (!presetn)
    exec && op == mise_pkg::OP_XOR_IMM |=> flags.c == $past(flags.c) && flags.dc == $past(flags.dc)
    && flags.z == (accumulator == 8'h00)) // RL12
    else $error("xor flags wrong");
  a_xor_file_zero: assert property (@(posedge pclk) disable iff (!presetn)
    to_file && op == mise_pkg::OP_XOR_FILE |=> flags.z == ($past(alu_res) == 8'h00) && $stable(accumulator)) // RL14
    else $error("xor file zero wrong");
  a_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
    to_acc_alu |=> accumulator == $past(alu_res)) // RL4
    else $error("destination accumulator wrong");

endmodule

// ===== verification/mise_apb_master.sv
// apb master standing in for the software side of the executor
// assumes one clock, pready sampled at rising edges, no timescale directive
module mise_apb_master (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int hang = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // ----------------------------------------
  // one transfer, held until pready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? wd : 32'h0000_0000;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== verification/test_mise_top.sv
// self-checking bench for the instruction subset executor
// assumes the apb register map and command word of the executor package
module test_mise_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic er;
  int errors = 0;
  int n_checks = 0;
  mise_top mise_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
  mise_apb_master mise_apb_master_inst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    mise_apb_master_inst.xfer(1'b1, a, d, x, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    mise_apb_master_inst.xfer(1'b0, a, 32'h0000_0000, x, e);
    check(x, exp);
  endtask
  task automatic cmd(input logic [3:0] op, input logic d, input logic [5:0] a, input logic [7:0] imm);
    mise_pkg::mise_cmd_type c;
    c = '0;
    c.op = op;
    c.dest = d;
    c.addr = a;
    c.imm = imm;
    wr(mise_pkg::OFS_CMD, {8'h00, c});
  endtask
  // preload, execute, then check both destinations and flags
  task automatic run_op(input logic [3:0] op, input logic d, input logic [5:0] a, input logic [7:0] imm,
                        input logic [7:0] fv, input logic [7:0] av, input logic [2:0] fp,
                        input logic [7:0] res, input logic [2:0] fx);
    logic [7:0] fa;
    fa = mise_pkg::OFS_FILE_BASE + {a, 2'b00};
    wr(fa, {24'h0, fv});
    wr(mise_pkg::OFS_ACC, {24'h0, av});
    wr(mise_pkg::OFS_FLAGS, {29'h0, fp});
    cmd(op, d, a, imm);
    rdc(fa, {24'h0, d ? res : fv});
    rdc(mise_pkg::OFS_ACC, {24'h0, d ? av : res});
    rdc(mise_pkg::OFS_FLAGS, {29'h0, fx});
  endtask
  task automatic end_sim;
    errors += mise_apb_master_inst.hang;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    end_sim();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int k;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 1; k <= 6; k++) rdc(8'(4 * k), 32'h0000_0000);
    mise_apb_master_inst.xfer(1'b0, 8'h1c, 32'h0, rv, er);
    check({31'h0, er}, 32'h1);
    check(rv, 32'h0);
    wr(8'h1c, 32'h0000_00ff);
    rdc(8'h1c, 32'h0);
    $display("test reset and map done");
    wr(mise_pkg::OFS_ACC, 32'h0000_00aa);
    wr(mise_pkg::OFS_FLAGS, 32'h0000_0005);
    cmd(mise_pkg::OP_WR_SPECIAL, 1'b0, 6'h00, 8'h0f);
    rdc(8'hbc, 32'h0000_00aa);
    wr(8'h80, 32'h0000_0055);
    cmd(mise_pkg::OP_RD_SPECIAL, 1'b0, 6'h00, 8'h00);
    rdc(mise_pkg::OFS_ACC, 32'h0000_0055);
    rdc(mise_pkg::OFS_FLAGS, 32'h0000_0005);
    $display("test special page done");
    run_op(mise_pkg::OP_SUB_FILE, 1'b1, 6'h02, 8'h00, 8'h05, 8'h06, 3'h7, 8'hff, 3'h0);
    run_op(mise_pkg::OP_SUB_FILE, 1'b0, 6'h03, 8'h00, 8'h06, 8'h05, 3'h0, 8'h01, 3'h3);
    run_op(mise_pkg::OP_SUB_FILE, 1'b0, 6'h0f, 8'h00, 8'h05, 8'h05, 3'h0, 8'h00, 3'h7);
    run_op(mise_pkg::OP_SUB_IMM, 1'b0, 6'h04, 8'h05, 8'h11, 8'h06, 3'h7, 8'hff, 3'h0);
    run_op(mise_pkg::OP_SUB_IMM, 1'b0, 6'h04, 8'h06, 8'h11, 8'h05, 3'h0, 8'h01, 3'h3);
    run_op(mise_pkg::OP_SUB_IMM, 1'b0, 6'h04, 8'h10, 8'h11, 8'h01, 3'h0, 8'h0f, 3'h1);
    run_op(mise_pkg::OP_SWAP, 1'b1, 6'h05, 8'h00, 8'ha5, 8'h00, 3'h5, 8'h5a, 3'h5);
    run_op(mise_pkg::OP_SWAP, 1'b0, 6'h06, 8'h00, 8'h3c, 8'h00, 3'h2, 8'hc3, 3'h2);
    run_op(mise_pkg::OP_XOR_FILE, 1'b1, 6'h07, 8'h00, 8'ha5, 8'hf0, 3'h3, 8'h55, 3'h3);
    run_op(mise_pkg::OP_XOR_FILE, 1'b0, 6'h08, 8'h00, 8'h33, 8'h33, 3'h0, 8'h00, 3'h4);
    run_op(mise_pkg::OP_XOR_IMM, 1'b0, 6'h09, 8'ha5, 8'h00, 8'hf0, 3'h7, 8'h55, 3'h3);
    run_op(mise_pkg::OP_XOR_IMM, 1'b0, 6'h09, 8'h5a, 8'h00, 8'h5a, 3'h3, 8'h00, 3'h7);
    $display("test alu ops done");
    wr(mise_pkg::OFS_T0MODE, 32'h0000_003c);
    wr(mise_pkg::OFS_ACC, 32'h0000_0000);
    cmd(mise_pkg::OP_RD_T0MODE, 1'b0, 6'h00, 8'h00);
    rdc(mise_pkg::OFS_ACC, 32'h0000_003c);
    rdc(mise_pkg::OFS_FLAGS, 32'h0000_0007);
    $display("test timer mode read done");
    wr(mise_pkg::OFS_ROM_ADDR, 32'h0000_0234);
    wr(mise_pkg::OFS_ROM_DATA, 32'h0000_35aa);
    wr(mise_pkg::OFS_ROM_ADDR, 32'h0000_0734);
    wr(mise_pkg::OFS_ROM_DATA, 32'h0000_0f0f);
    wr(mise_pkg::OFS_TBL_PTR, 32'h0000_00fa);
    wr(mise_pkg::OFS_ACC, 32'h0000_0034);
    cmd(mise_pkg::OP_TABLE, 1'b0, 6'h00, 8'h00);
    @(negedge pclk);
    check({31'h0, busy}, 32'h1);
    // issued while busy: the table read ends with its setup phase, no stall, then it must see the table result
    cmd(mise_pkg::OP_WR_T0MODE, 1'b0, 6'h00, 8'h00);
    rdc(mise_pkg::OFS_ACC, 32'h0000_00aa);
    rdc(mise_pkg::OFS_TBL_DATA, 32'h0000_0035);
    rdc(mise_pkg::OFS_T0MODE, 32'h0000_00aa);
    rdc(mise_pkg::OFS_FLAGS, 32'h0000_0007);
    rdc(mise_pkg::OFS_STATUS, 32'h0000_0000);
    $display("test table read done");
    end_sim();
  end
endmodule
